// *** cml_pkg.sv ***
// Shared constants and types for the configuration mode loader
package cml_pkg;
  localparam int WORD_W = 32;
  localparam int IR_W = 6;
  localparam logic [5:0] IR_CFG_IN = 6'h05;
  localparam logic [5:0] IR_BYPASS = 6'h3F;
  localparam logic [5:0] IR_CAPTURE = 6'h01;
  localparam logic [1:0] WIDTH_X8 = 2'h0;
  localparam logic [1:0] WIDTH_X16 = 2'h1;
  localparam logic [1:0] WIDTH_X32 = 2'h2;
  localparam logic [23:0] MODE_MAP_DEFAULT = 24'h2E2FA8;
  localparam int CLK_PERIOD_NS = 4;
  localparam int CONFIG_CLOCK_HALF_NS = 20;
  localparam int CONFIG_CLOCK_HALF_CYC = (CONFIG_CLOCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    CM_MSERIAL, CM_SSERIAL, CM_MPAR, CM_SPAR, CM_JTAG, CM_MSPI, CM_FLASH_UP, CM_FLASH_DN
  } cml_mode_t;
  typedef enum logic [1:0] {PH_WAIT_INIT, PH_LOAD, PH_DONE} cml_phase_t;
  typedef enum logic [3:0] {
    T_RESET, T_IDLE, T_SEL_DR, T_CAP_DR, T_SH_DR, T_EX1_DR, T_PA_DR, T_EX2_DR, T_UP_DR,
    T_SEL_IR, T_CAP_IR, T_SH_IR, T_EX1_IR, T_PA_IR, T_EX2_IR, T_UP_IR
  } cml_tap_t;
endpackage

// *** cml_buf2.sv ***
// Two-entry word buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module cml_buf2 #(
  parameter int W = 32
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  logic [W-1:0] mem_reg [2];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count
  assign in_ready_out = (count_reg != 2'h2);
  assign out_valid_out = (count_reg != 2'h0);
  assign out_data_out = mem_reg[rd_ptr_reg];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // Storage needs no reset; only valid entries are ever read
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// *** cml_top.sv ***
// Configuration mode selection, clocking and pin control
`timescale 1ns/1ps
`default_nettype none
module cml_top #(
  parameter logic [23:0] MODE_MAP = cml_pkg::MODE_MAP_DEFAULT,
  parameter int HALF_CYC = cml_pkg::CONFIG_CLOCK_HALF_CYC
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [2:0] mode_pins_in,
  input wire logic init_pin_in,
  output logic init_pin_out,
  output logic init_pin_oe_out,
  input wire logic config_clock_pin_in,
  output logic config_clock_pin_out,
  output logic config_clock_pin_oe_out,
  output logic config_clock_pullup_out,
  input wire logic serial_data_in,
  output logic shared_out,
  output logic done_out,
  input wire logic preconfig_pullup_disable_in,
  output logic preconfig_pullup_en_out,
  output logic user_io_release_out,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  input wire logic par_cs_n_in,
  input wire logic parallel_port_direction_in,
  input wire logic [1:0] par_width_in,
  input wire logic [cml_pkg::WORD_W-1:0] par_data_in,
  output logic [cml_pkg::WORD_W-1:0] par_data_out,
  output logic par_data_oe_out,
  input wire logic [cml_pkg::WORD_W-1:0] readback_word_in,
  output logic abort_out,
  input wire logic persist_in,
  input wire logic upset_detect_in,
  input wire logic crc_error_in,
  input wire logic readback_crc_en_in,
  input wire logic readback_crc_error_in,
  input wire logic load_done_in,
  output logic [2:0] mode_code_out,
  output logic jtag_cfg_active_out,
  output logic [cml_pkg::WORD_W-1:0] word_out,
  output logic word_valid_out,
  input wire logic word_ready_in
);
  import cml_pkg::*;
  localparam int SW = 44;
  logic [SW-1:0] pins;
  logic [SW-1:0] s1_reg;
  logic [SW-1:0] s2_reg;
  logic [1:0] edge_reg;
  logic [2:0] mode_s;
  logic init_s, config_clock_s, din_s, cs_n_s, dir_s, tck_s, tms_s, tdi_s, pud_s;
  logic [WORD_W-1:0] pdat_s;
  logic config_clock_rise, tck_rise, tck_fall;
  cml_phase_t phase_reg;
  cml_mode_t mode_reg;
  cml_mode_t decoded;
  logic is_master, is_serial, is_par, jtag_cfg;
  logic [7:0] div_reg;
  logic config_clock_reg;
  logic clk_run, master_tick, cfg_step;
  logic [WORD_W-1:0] asm_reg;
  logic [WORD_W-1:0] asm_next;
  logic [5:0] cnt_reg;
  logic [6:0] cnt_next;
  logic [5:0] step_bits;
  logic [1:0] eff_width;
  logic cfg_push;
  logic dir_prev_reg, abort_reg, crc_err_reg;
  cml_tap_t tap_reg;
  logic [IR_W-1:0] ir_reg;
  logic [IR_W-1:0] ir_sh_reg;
  logic [WORD_W-1:0] jdr_reg;
  logic [4:0] jcnt_reg;
  logic byp_reg, tdo_reg, tdo_oe_reg, jtag_push;
  logic buf_in_valid, buf_in_ready;
  logic [WORD_W-1:0] buf_in_data;
  logic init_oe_reg, done_reg, busy_reg, dout_reg, pud_reg, poe_reg;
  logic [WORD_W-1:0] pout_reg;

  // Every pin input except par_width_in passes two flops before anything reads it
  assign pins = {mode_pins_in, init_pin_in, config_clock_pin_in, serial_data_in, par_cs_n_in,
                 parallel_port_direction_in, tck_in, tms_in, tdi_in, preconfig_pullup_disable_in, par_data_in};
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s1_reg <= '0;
      s2_reg <= '0;
      edge_reg <= 2'h0;
    end else begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      edge_reg <= {config_clock_s, tck_s};
    end
  end
  assign {mode_s, init_s, config_clock_s, din_s, cs_n_s, dir_s, tck_s, tms_s, tdi_s, pud_s, pdat_s} = s2_reg;
  assign config_clock_rise = config_clock_s & ~edge_reg[1];
  assign tck_rise = tck_s & ~edge_reg[0];
  assign tck_fall = ~tck_s & edge_reg[0];

  // Mode code lookup through the table parameter
  assign decoded = cml_mode_t'(MODE_MAP[3*mode_s +: 3]);
  assign is_master = (mode_reg inside {CM_MSERIAL, CM_MPAR, CM_MSPI, CM_FLASH_UP, CM_FLASH_DN});
  assign is_serial = (mode_reg inside {CM_MSERIAL, CM_SSERIAL, CM_MSPI});
  assign is_par = (mode_reg inside {CM_MPAR, CM_SPAR, CM_FLASH_UP, CM_FLASH_DN});
  assign jtag_cfg = (ir_reg == IR_CFG_IN);

  // Phase sequence; mode is caught once, so later pin changes cannot disturb it
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_reg <= PH_WAIT_INIT;
      mode_reg <= CM_MSERIAL;
    end else begin
      unique case (phase_reg)
        PH_WAIT_INIT: begin
          if (init_s) begin
            mode_reg <= decoded;
            phase_reg <= PH_LOAD;
          end
        end
        PH_LOAD: begin
          if (load_done_in) begin
            phase_reg <= PH_DONE;
          end
        end
        PH_DONE: begin
          phase_reg <= PH_DONE;
        end
      endcase
    end
  end

  // Master clock divider; it halts while the buffer is full so no word is lost
  assign clk_run = is_master & ~jtag_cfg & buf_in_ready &
                   ((phase_reg == PH_LOAD) | ((phase_reg == PH_DONE) & (persist_in | upset_detect_in)));
  assign master_tick = clk_run & (div_reg == 8'(HALF_CYC - 1)) & ~config_clock_reg;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_reg <= 8'h00;
      config_clock_reg <= 1'b0;
    end else if (clk_run) begin
      if (div_reg == 8'(HALF_CYC - 1)) begin
        div_reg <= 8'h00;
        config_clock_reg <= ~config_clock_reg;
      end else begin
        div_reg <= div_reg + 8'h01;
      end
    end else begin
      div_reg <= 8'h00;
      config_clock_reg <= 1'b0;
    end
  end
  assign config_clock_pin_out = config_clock_reg;
  assign config_clock_pin_oe_out = clk_run | (is_master & ~jtag_cfg & (phase_reg == PH_LOAD));
  assign config_clock_pullup_out = ~config_clock_pin_oe_out;

  // One configuration data step per config_clock rise, never during test-port loading
  assign cfg_step = (phase_reg == PH_LOAD) & ~jtag_cfg & (is_master ? master_tick : config_clock_rise) &
                    (is_serial | (is_par & ~cs_n_s & ~dir_s));

  // Master parallel and flash modes cannot run x32; such a request falls back to x16
  always_comb begin
    eff_width = par_width_in;
    if (par_width_in == WIDTH_X32 && mode_reg != CM_SPAR) begin
      eff_width = WIDTH_X16;
    end else if (par_width_in > WIDTH_X32) begin
      eff_width = WIDTH_X8;
    end
  end

  // Serial bits or parallel lanes packed into one word, first item in the high bits
  always_comb begin
    step_bits = 6'h01;
    asm_next = {asm_reg[WORD_W-2:0], din_s};
    if (is_par) begin
      unique case (eff_width)
        WIDTH_X16: begin
          step_bits = 6'h10;
          asm_next = {asm_reg[15:0], pdat_s[15:0]};
        end
        WIDTH_X32: begin
          step_bits = 6'h20;
          asm_next = pdat_s;
        end
        default: begin
          step_bits = 6'h08;
          asm_next = {asm_reg[23:0], pdat_s[7:0]};
        end
      endcase
    end
    cnt_next = {1'b0, cnt_reg} + {1'b0, step_bits};
  end
  assign cfg_push = cfg_step & (cnt_next == 7'h20);

  // Assembly state, direction tracking and abort
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      asm_reg <= '0;
      cnt_reg <= 6'h00;
      dir_prev_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      dir_prev_reg <= dir_s;
      abort_reg <= 1'b0;
      if (is_par && phase_reg == PH_LOAD && !cs_n_s && dir_s != dir_prev_reg) begin
        abort_reg <= 1'b1;
        cnt_reg <= 6'h00;
      end else if (cfg_step) begin
        asm_reg <= asm_next;
        cnt_reg <= cfg_push ? 6'h00 : cnt_next[5:0];
      end
    end
  end
  assign abort_out = abort_reg;

  // Test-port state machine on each test-clock rise
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tap_reg <= T_RESET;
    end else if (tck_rise) begin
      unique case (tap_reg)
        T_RESET: tap_reg <= tms_s ? T_RESET : T_IDLE;
        T_IDLE: tap_reg <= tms_s ? T_SEL_DR : T_IDLE;
        T_SEL_DR: tap_reg <= tms_s ? T_SEL_IR : T_CAP_DR;
        T_CAP_DR: tap_reg <= tms_s ? T_EX1_DR : T_SH_DR;
        T_SH_DR: tap_reg <= tms_s ? T_EX1_DR : T_SH_DR;
        T_EX1_DR: tap_reg <= tms_s ? T_UP_DR : T_PA_DR;
        T_PA_DR: tap_reg <= tms_s ? T_EX2_DR : T_PA_DR;
        T_EX2_DR: tap_reg <= tms_s ? T_UP_DR : T_SH_DR;
        T_UP_DR: tap_reg <= tms_s ? T_SEL_DR : T_IDLE;
        T_SEL_IR: tap_reg <= tms_s ? T_RESET : T_CAP_IR;
        T_CAP_IR: tap_reg <= tms_s ? T_EX1_IR : T_SH_IR;
        T_SH_IR: tap_reg <= tms_s ? T_EX1_IR : T_SH_IR;
        T_EX1_IR: tap_reg <= tms_s ? T_UP_IR : T_PA_IR;
        T_PA_IR: tap_reg <= tms_s ? T_EX2_IR : T_PA_IR;
        T_EX2_IR: tap_reg <= tms_s ? T_UP_IR : T_SH_IR;
        T_UP_IR: tap_reg <= tms_s ? T_SEL_DR : T_IDLE;
      endcase
    end
  end

  // Test-port registers take test data in on the rise, instruction least significant bit first, configuration data most significant bit first
  assign jtag_push = tck_rise & (tap_reg == T_SH_DR) & jtag_cfg & (jcnt_reg == 5'h1F);
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ir_reg <= IR_BYPASS;
      ir_sh_reg <= IR_CAPTURE;
      jdr_reg <= '0;
      jcnt_reg <= 5'h00;
      byp_reg <= 1'b0;
    end else if (tck_rise) begin
      unique case (tap_reg)
        T_RESET: ir_reg <= IR_BYPASS;
        T_CAP_IR: ir_sh_reg <= IR_CAPTURE;
        T_SH_IR: ir_sh_reg <= {tdi_s, ir_sh_reg[IR_W-1:1]};
        T_UP_IR: ir_reg <= ir_sh_reg;
        T_CAP_DR: begin
          jcnt_reg <= 5'h00;
          byp_reg <= 1'b0;
        end
        T_SH_DR: begin
          if (jtag_cfg) begin
            jdr_reg <= {jdr_reg[WORD_W-2:0], tdi_s};
            jcnt_reg <= jcnt_reg + 5'h01;
          end else begin
            byp_reg <= tdi_s;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Test data out moves on the fall and floats outside the two shift states
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_reg <= (tap_reg == T_SH_IR) | (tap_reg == T_SH_DR);
      if (tap_reg == T_SH_IR) begin
        tdo_reg <= ir_sh_reg[0];
      end else begin
        tdo_reg <= jtag_cfg ? jdr_reg[WORD_W-1] : byp_reg;
      end
    end
  end
  assign tdo_out = tdo_reg;
  assign tdo_oe_out = tdo_oe_reg;

  // Words join the buffer; the test port cannot stall, so its words win the slot
  assign buf_in_valid = jtag_push | cfg_push;
  assign buf_in_data = jtag_push ? {jdr_reg[WORD_W-2:0], tdi_s} : asm_next;
  cml_buf2 #(.W(WORD_W)) u_buf (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(buf_in_valid),
    .in_ready_out(buf_in_ready),
    .in_data_in(buf_in_data),
    .out_valid_out(word_valid_out),
    .out_ready_in(word_ready_in),
    .out_data_out(word_out)
  );

  // Pin status: init error flag, done, busy or daisy-chain data, pull-ups, readback
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      crc_err_reg <= 1'b0;
      init_oe_reg <= 1'b0;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
      dout_reg <= 1'b0;
      pud_reg <= 1'b1;
      poe_reg <= 1'b0;
      pout_reg <= '0;
    end else begin
      if (phase_reg == PH_LOAD && crc_error_in) begin
        crc_err_reg <= 1'b1;
      end
      init_oe_reg <= ((phase_reg == PH_LOAD) & (crc_err_reg | crc_error_in)) |
                     ((phase_reg == PH_DONE) & readback_crc_en_in & readback_crc_error_in);
      done_reg <= (phase_reg == PH_DONE);
      busy_reg <= is_par & ~buf_in_ready;
      dout_reg <= is_serial & asm_reg[WORD_W-1];
      pud_reg <= ~pud_s;
      poe_reg <= is_par & (phase_reg != PH_WAIT_INIT) & ~cs_n_s & dir_s & ~jtag_cfg;
      pout_reg <= readback_word_in;
    end
  end
  assign init_pin_out = 1'b0;
  assign init_pin_oe_out = init_oe_reg;
  assign done_out = done_reg;
  assign user_io_release_out = done_reg;
  assign shared_out = is_serial ? dout_reg : busy_reg;
  assign preconfig_pullup_en_out = pud_reg;
  assign par_data_oe_out = poe_reg;
  assign par_data_out = pout_reg;
  assign mode_code_out = mode_reg;
  assign jtag_cfg_active_out = jtag_cfg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_dir_flip;
    is_par && phase_reg == PH_LOAD && !cs_n_s && $changed(dir_s);
  endsequence
  sequence s_load_end;
    phase_reg == PH_LOAD && load_done_in;
  endsequence

  chk_mode_latch: assert property (phase_reg == PH_WAIT_INIT && init_s |=> mode_reg == $past(decoded))
    else $error("mode not latched at init rise");
  chk_master_clock: assert property (phase_reg == PH_LOAD && is_master && !jtag_cfg |-> config_clock_pin_oe_out)
    else $error("master mode not driving config clock");
  chk_clock_stop: assert property (phase_reg == PH_DONE && !persist_in && !upset_detect_in
    |-> !config_clock_pin_oe_out && config_clock_pullup_out)
    else $error("config clock still driven after done");
  chk_slave_input: assert property (!is_master |-> !config_clock_pin_oe_out)
    else $error("slave mode drives config clock");
  chk_jtag_excl: assert property (jtag_cfg |-> !cfg_step && !cfg_push ##1 !par_data_oe_out)
    else $error("other interface active during test-port load");
  chk_done_level: assert property (s_load_end |=> ##1 done_out ##1 done_out)
    else $error("done not raised after load end");
  chk_init_input: assert property (phase_reg == PH_WAIT_INIT |-> !init_pin_oe_out)
    else $error("init driven before mode sampling");
  chk_tdo_quiet: assert property (tck_fall && tap_reg == T_IDLE |=> !tdo_oe_out)
    else $error("test data out driven outside shift");
  chk_abort_seq: assert property (s_dir_flip |=> abort_out ##1 !abort_out)
    else $error("direction change under select not aborted");
  chk_pullup_sense: assert property (pud_s |=> !preconfig_pullup_en_out)
    else $error("pull-ups left on while disabled");
endmodule
`default_nettype wire

// *** cml_host.sv ***
// Behavioural slave-mode configuration source: supplies config_clock and serial data
`timescale 1ns/1ps
`default_nettype none
module cml_host (
  output logic config_clock_out,
  output logic sdata_out
);
  // Clock stands low between frames, since the source only clocks while it has data
  initial begin
    config_clock_out = 1'b0;
    sdata_out = 1'b0;
  end

  // One 160 ns clock period; parallel beats use it bare, the data bus is set by the bench
  task automatic pulse();
    #80 config_clock_out = 1'b1;
    #80 config_clock_out = 1'b0;
  endtask

  // One word, MSB first, one bit per 160 ns clock period
  task automatic send_word(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      sdata_out = w[i];
      pulse();
    end
    sdata_out = ~w[0]; // Data line is no longer held once the frame ends
  endtask
endmodule
`default_nettype wire

// *** cml_top_bench.sv ***
// Self-checking bench for the configuration mode loader
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module cml_top_bench;
  import cml_pkg::*;
  localparam int HC = 2;
  logic clk_in = 0, reset_n_in = 0, init_drv = 0, persist_in = 0, load_done_in = 0, crc_error_in = 0;
  logic pud_in = 0, tck_in = 0, tms_in = 1, tdi_in = 0, par_cs_n_in = 1, dir_in = 0, word_ready_in = 0;
  logic [2:0] mode_pins_in = 3'h0;
  logic [WORD_W-1:0] rb_word = 32'h0000_0000, par_data = 32'h0000_0000;
  logic [1:0] par_width = WIDTH_X8;
  logic upset_in = 0, rb_crc_en = 0, rb_crc_err = 0;
  logic init_oe, init_o, cc_o, cc_oe, cc_pu, shared_o, done_o, pu_en, rel_o, tdo_o, tdo_oe, par_oe, abort_o;
  logic jtag_act, wvalid, host_config_clock, host_sd;
  logic [2:0] mode_code;
  logic [WORD_W-1:0] par_q, word_q;
  int miscompares = 0, n_checks = 0;

  // System clock, 4 ns period
  always #2 clk_in = ~clk_in;

  // Open-drain init and shared config_clock wire levels
  wire init_wire = init_oe ? init_o : init_drv;
  wire config_clock_wire = cc_oe ? cc_o : host_config_clock;

  cml_host i_cml_host (.config_clock_out(host_config_clock), .sdata_out(host_sd));

  cml_top #(.MODE_MAP(MODE_MAP_DEFAULT), .HALF_CYC(HC)) i_cml_top (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .mode_pins_in(mode_pins_in), .init_pin_in(init_wire),
    .init_pin_out(init_o), .init_pin_oe_out(init_oe), .config_clock_pin_in(config_clock_wire),
    .config_clock_pin_out(cc_o), .config_clock_pin_oe_out(cc_oe), .config_clock_pullup_out(cc_pu),
    .serial_data_in(host_sd), .shared_out(shared_o), .done_out(done_o), .preconfig_pullup_disable_in(pud_in),
    .preconfig_pullup_en_out(pu_en), .user_io_release_out(rel_o), .tck_in(tck_in), .tms_in(tms_in),
    .tdi_in(tdi_in), .tdo_out(tdo_o), .tdo_oe_out(tdo_oe), .par_cs_n_in(par_cs_n_in),
    .parallel_port_direction_in(dir_in), .par_width_in(par_width), .par_data_in(par_data),
    .par_data_out(par_q), .par_data_oe_out(par_oe), .readback_word_in(rb_word), .abort_out(abort_o),
    .persist_in(persist_in), .upset_detect_in(upset_in), .crc_error_in(crc_error_in), .readback_crc_en_in(rb_crc_en),
    .readback_crc_error_in(rb_crc_err), .load_done_in(load_done_in), .mode_code_out(mode_code),
    .jtag_cfg_active_out(jtag_act), .word_out(word_q), .word_valid_out(wvalid), .word_ready_in(word_ready_in));

  // Single place where the run ends
  task automatic give_verdict();
    if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Step past n rising edges and let their updates settle
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // Reset, hold init low a while, then release it with the given mode code
  task automatic start(input logic [2:0] code);
    reset_n_in <= 0;
    init_drv <= 0;
    load_done_in <= 0;
    mode_pins_in <= code;
    cyc(5);
    reset_n_in <= 1;
    cyc(10);
    `CHK(done_o, 1'b0)
    `CHK(mode_code, 3'h0)
    `CHK(init_oe, 1'b0)
    init_drv <= 1;
    cyc(5);
    `CHK(mode_code, MODE_MAP_DEFAULT[3*code +: 3])
    mode_pins_in <= ~code;
    cyc(5);
    `CHK(mode_code, MODE_MAP_DEFAULT[3*code +: 3])
  endtask

  // Wait for a buffered word, compare it, then accept it with a one-cycle ready
  task automatic pop(input logic [WORD_W-1:0] e);
    int k;
    for (k = 0; k < 2000 && wvalid !== 1'b1; k++) cyc(1);
    if (k == 2000) begin
      miscompares++;
      give_verdict();
    end
    `CHK(word_q, e)
    word_ready_in <= 1;
    cyc(1);
    word_ready_in <= 0;
    cyc(1);
  endtask

  // Slave serial: two words fill the buffer, a third is refused, then done
  task automatic t_serial();
    start(3'h7);
    `CHK(pu_en, 1'b1)
    `CHK(cc_oe, 1'b0)
    pud_in <= 1;
    i_cml_host.send_word(32'hA5C3_0F96);
    `CHK(pu_en, 1'b0)
    `CHK(shared_o, 1'b1)
    i_cml_host.send_word(32'h1234_5678);
    `CHK(shared_o, 1'b0)
    i_cml_host.send_word(32'hFFFF_0001);
    pop(32'hA5C3_0F96);
    pop(32'h1234_5678);
    cyc(3);
    `CHK(wvalid, 1'b0)
    load_done_in <= 1;
    cyc(4);
    `CHK(done_o, 1'b1)
    `CHK(rel_o, 1'b1)
    rb_crc_en <= 1;
    rb_crc_err <= 1;
    cyc(2);
    `CHK(init_oe, 1'b1)
    rb_crc_en <= 0;
    cyc(2);
    `CHK(init_oe, 1'b0)
    rb_crc_err <= 0;
  endtask

  // Master serial: clock rate, then clock stops after done unless persist or upset detect is set
  task automatic t_master();
    int rises;
    logic prev;
    for (int p = 0; p < 3; p++) begin
      persist_in <= (p == 1);
      upset_in <= (p == 2);
      start(3'h0);
      `CHK(cc_oe, 1'b1)
      rises = 0;
      for (int i = 0; i < 40; i++) begin
        prev = cc_o;
        cyc(1);
        if (cc_o === 1'b1 && prev === 1'b0) rises++;
      end
      `CHK(rises, 40 / (2 * HC))
      load_done_in <= 1;
      cyc(4);
      `CHK(cc_oe, p != 0)
      `CHK(cc_pu, p == 0)
    end
    persist_in <= 0;
    upset_in <= 0;
  endtask

  // Slave parallel: readback, abort, x16 and x32 writes with busy, sticky error flag
  task automatic t_par();
    int k;
    start(3'h6);
    rb_word <= 32'hC0DE_5A17;
    dir_in <= 1; // Direction settles while deselected
    cyc(4);
    par_cs_n_in <= 0;
    cyc(6);
    `CHK(par_oe, 1'b1)
    `CHK(par_q, 32'hC0DE_5A17)
    par_cs_n_in <= 1;
    cyc(6);
    `CHK(par_oe, 1'b0)
    par_cs_n_in <= 0;
    cyc(4);
    dir_in <= 0;
    for (k = 0; k < 10 && abort_o !== 1'b1; k++) cyc(1);
    `CHK(k < 10, 1'b1)
    if (k == 10) give_verdict();
    cyc(1);
    `CHK(abort_o, 1'b0)
    par_width <= WIDTH_X16;
    par_data <= 32'h0000_BEEF;
    i_cml_host.pulse();
    par_data <= 32'h0000_CAFE;
    i_cml_host.pulse();
    par_width <= WIDTH_X32;
    par_data <= 32'h1357_9BDF;
    i_cml_host.pulse();
    cyc(3);
    `CHK(shared_o, 1'b1)
    pop(32'hBEEF_CAFE);
    pop(32'h1357_9BDF);
    par_cs_n_in <= 1;
    crc_error_in <= 1;
    cyc(1);
    crc_error_in <= 0;
    cyc(3);
    `CHK(init_oe, 1'b1)
    `CHK(done_o, 1'b0)
  endtask

  // One test clock period of 160 ns
  task automatic tick(input logic ms, input logic di);
    tms_in <= ms;
    tdi_in <= di;
    cyc(20);
    tck_in <= 1;
    cyc(20);
    tck_in <= 0;
  endtask

  // Test-port load while the mode pins select slave serial
  task automatic t_jtag();
    logic [4:0] pre;
    logic [WORD_W-1:0] w;
    pre = 5'b00110;
    w = 32'h9E37_79B9;
    start(3'h7);
    for (int i = 0; i < 5; i++) tick(pre[i], 1'b0);
    cyc(5);
    `CHK(tdo_o, IR_CAPTURE[0])
    for (int i = 0; i < IR_W; i++) begin
      tick(i == IR_W - 1, IR_CFG_IN[i]);
      if (i == 2) begin
        cyc(5);
        `CHK(tdo_oe, 1'b1)
      end
    end
    tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
    cyc(5);
    `CHK(tdo_oe, 1'b0)
    `CHK(jtag_act, 1'b1)
    i_cml_host.send_word(32'h0F0F_0F0F);
    cyc(10);
    `CHK(wvalid, 1'b0)
    for (int i = 0; i < 3; i++) tick(i == 0, 1'b0);
    for (int i = 0; i < 32; i++) tick(i == 31, w[31 - i]);
    tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
    pop(w);
  endtask

  // Main sequence
  initial begin
    t_serial();
    t_master();
    t_par();
    t_jtag();
    give_verdict();
  end
endmodule
`default_nettype wire
